// *** bench/bypass_valve_model.sv ***
`timescale 1ns/1ps
module bypass_valve_model (
    input  wire logic        clk_i,
    input  wire logic        drive_i,
    output logic      [31:0] hi_len_o,
    output logic      [31:0] per_len_o
);
    logic [31:0] hi_cnt  = 32'h0;
    logic [31:0] per_cnt = 32'h0;
    logic        last    = 1'b0;
    // Solenoid is open while driven; each rising edge closes one measured period
    always_ff @(posedge clk_i) begin
        last <= drive_i;
        if (drive_i && !last) begin
            per_len_o <= per_cnt;
            hi_len_o  <= hi_cnt;
            per_cnt   <= 32'h1;
            hi_cnt    <= 32'h1;
        end else begin
            per_cnt <= per_cnt + 32'h1;
            hi_cnt  <= hi_cnt + {31'h0, drive_i};
        end
    end
endmodule : bypass_valve_model

// *** bench/idle_air_pwm_control_test.sv ***
`timescale 1ns/1ps
module idle_air_pwm_control_test;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ac = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, hi_len, per_len;
    logic pready, pslverr, err, comp;
    logic [3:0] valve;
    logic signed [7:0] spark;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    logic [15:0] rpm = 16'h0400;
    logic [7:0] thr = 8'h00;
    logic [31:0] tbl [9] = '{32'h1040, 32'h0428, 32'h2000, 32'h2450, 32'h2600, 32'h3000,
                             32'h3101, 32'h3203, 32'h3402};
    idle_air_pwm_control #(.MS_CYCLES(40), .S_TICKS(2)) u_dut (.CLK_I(clk), .SYS_RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .ENGINE_RPM_I(rpm),
        .THROTTLE_POSITION_INPUT_I(thr), .COOLANT_I(8'h00), .VEHICLE_SPEED_I(8'h00),
        .AC_REQUEST_I(ac), .ENGINE_STARTED_I(1'b0), .BYPASS_AIR_VALVE_O(valve),
        .COMPRESSOR_O(comp), .SPARK_TRIM_O(spark));
    bypass_valve_model u_valve (.clk_i(clk), .drive_i(valve[2]), .hi_len_o(hi_len),
        .per_len_o(per_len));
    initial forever #12.5 clk = ~clk;
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({27'h0, comp, valve}, 32'h0);
        foreach (tbl[i]) apb(1'b1, idle_air_pkg::A_TBL_WR, tbl[i]);
        apb(1'b1, idle_air_pkg::A_PERIOD, 32'd10);
        apb(1'b0, idle_air_pkg::A_PERIOD, 32'h0);
        check(rd, 32'd10);
        apb(1'b1, idle_air_pkg::A_LOOP_SPD, 32'h0bb8_0190);
        apb(1'b1, idle_air_pkg::A_THR_LVL, 32'h0505);
        apb(1'b1, idle_air_pkg::A_TIMES, 32'h0000_0200);
        apb(1'b1, idle_air_pkg::A_CTRL, 32'h5);
        apb(1'b0, 12'h030, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        repeat (1000) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_TARGET, 32'h0);
        check(rd, 32'h400);
        check({28'h0, valve & 4'hb}, 32'h0);
        check(per_len, 32'd400);
        check(hi_len, 32'd160);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({25'h0, rd[14:8]}, 32'd40);
        ac <= 1'b1;
        repeat (60) @(posedge clk);
        check({31'h0, comp}, 32'h0);
        repeat (240) @(posedge clk);
        check({31'h0, comp}, 32'h1);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({17'h0, rd[14:0]}, 32'h2d00);
        // Below target beyond deadzone: correction climbs to its ceiling
        rpm <= 16'h03e0;
        repeat (800) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({17'h0, rd[14:0]}, 32'h3c0f);
        check({24'h0, spark}, 32'h03);
        // Above target beyond deadzone: correction falls to its floor
        rpm <= 16'h0440;
        repeat (1000) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({17'h0, rd[14:0]}, 32'h28fb);
        check({24'h0, spark}, 32'hfe);
        rpm <= 16'h03ec;
        repeat (200) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({24'h0, rd[7:0]}, 32'hfb);
        rpm <= 16'h0428;
        thr <= 8'h04;
        repeat (200) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({17'h0, rd[14:0]}, 32'h2dfb);
        thr <= 8'h06;
        repeat (20) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({12'h0, rd[19:0]}, 32'h1_0000);
        thr <= 8'h00;
        repeat (20) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({12'h0, rd[19:0]}, 32'hc_2d00);
        rpm <= 16'h0100;
        repeat (400) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({23'h0, rd[19], rd[7:0]}, 32'h0);
        rpm <= 16'h0c00;
        repeat (400) @(posedge clk);
        apb(1'b0, idle_air_pkg::A_STATUS, 32'h0);
        check({23'h0, rd[19], rd[7:0]}, 32'h0);
        print_verdict();
    end
endmodule : idle_air_pwm_control_test

// *** src/idle_air_pkg.sv ***
package idle_air_pkg;

    // ****************************************************************
    // Widths and encodings
    // ****************************************************************
    localparam int  RPM_W       = 16;
    localparam int  PCT_W       = 8;
    localparam int  TEMP_W      = 8;
    localparam int  SPD_W       = 8;
    localparam int  TBL_AW      = 4;
    localparam int  OUT_N       = 4;

    localparam logic [7:0] PCT_MAX  = 8'h64;
    localparam int  DUTY_W      = 7;
    localparam logic [6:0] DUTY_FULL = 7'h64;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int  CLK_HZ      = 40000000;
    localparam int  US_CYCLES   = CLK_HZ / 1000000;
    localparam int  MS_US       = 1000;
    localparam int  S_MS        = 1000;
    localparam int  PERIOD_US_DEF = 10000;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] A_CTRL      = 12'h000;
    localparam logic [11:0] A_LOOP_SPD  = 12'h004;
    localparam logic [11:0] A_THR_LVL   = 12'h008;
    localparam logic [11:0] A_CORR_LIM  = 12'h00c;
    localparam logic [11:0] A_DEADZONE  = 12'h010;
    localparam logic [11:0] A_TIMES     = 12'h014;
    localparam logic [11:0] A_RAISED    = 12'h018;
    localparam logic [11:0] A_COMP      = 12'h01c;
    localparam logic [11:0] A_STATUS    = 12'h020;
    localparam logic [11:0] A_TARGET    = 12'h024;
    localparam logic [11:0] A_TBL_WR    = 12'h028;
    localparam logic [11:0] A_PERIOD    = 12'h02c;

    localparam logic [1:0] TBL_OPEN     = 2'h0;
    localparam logic [1:0] TBL_BASE     = 2'h1;
    localparam logic [1:0] TBL_FOLLOW   = 2'h2;
    localparam logic [1:0] TBL_SPARK    = 2'h3;

    localparam int  CTRL_EN_BIT = 0;
    localparam int  CTRL_SEL_LO = 1;

    typedef struct packed {
        logic [RPM_W-1:0]  engine_rpm;
        logic [PCT_W-1:0]  throttle;
        logic [TEMP_W-1:0] coolant;
        logic [SPD_W-1:0]  vehicle_speed;
        logic              ac_request;
        logic              engine_started;
    } sensors_t;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b001,
        ST_ENTER = 3'b010,
        ST_LOOP  = 3'b100
    } idle_state_t;

endpackage : idle_air_pkg

// *** src/idle_air_pwm_control.sv ***
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module idle_air_pwm_control #(
    parameter int MS_CYCLES = 40000,
    parameter int S_TICKS   = 1000
) (
    input  wire logic                               CLK_I,
    input  wire logic                               SYS_RST_I,
    input  wire logic                               PSEL_I,
    input  wire logic                               PENABLE_I,
    input  wire logic                               PWRITE_I,
    input  wire logic [11:0]                        PADDR_I,
    input  wire logic [31:0]                        PWDATA_I,
    output logic      [31:0]                        PRDATA_O,
    output logic                                    PREADY_O,
    output logic                                    PSLVERR_O,
    input  wire logic [idle_air_pkg::RPM_W-1:0]     ENGINE_RPM_I,
    input  wire logic [idle_air_pkg::PCT_W-1:0]     THROTTLE_POSITION_INPUT_I,
    input  wire logic [idle_air_pkg::TEMP_W-1:0]    COOLANT_I,
    input  wire logic [idle_air_pkg::SPD_W-1:0]     VEHICLE_SPEED_I,
    input  wire logic                               AC_REQUEST_I,
    input  wire logic                               ENGINE_STARTED_I,
    output logic [idle_air_pkg::OUT_N-1:0]          BYPASS_AIR_VALVE_O,
    output logic                                    COMPRESSOR_O,
    output logic signed [7:0]                       SPARK_TRIM_O
);
    import idle_air_pkg::*;
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    sensors_t sens_meta_reg;
    sensors_t sens_reg;
    always_ff @(posedge CLK_I) begin
        sens_meta_reg <= '{ENGINE_RPM_I, THROTTLE_POSITION_INPUT_I, COOLANT_I,
                           VEHICLE_SPEED_I, AC_REQUEST_I, ENGINE_STARTED_I};
        sens_reg      <= sens_meta_reg;
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic        enable_reg;
    logic [1:0]  valve_output_select_reg;
    logic [15:0] loop_upper_speed_reg, loop_lower_speed_reg;
    logic [7:0]  throttle_enter_level_reg, throttle_exit_level_reg;
    logic signed [7:0] correction_ceiling_reg, correction_floor_reg;
    logic [15:0] lower_deadzone_reg, upper_deadzone_reg;
    logic [15:0] loop_update_interval_reg;
    logic [7:0]  ac_delay_reg, raised_hold_time_reg, flare_time_reg;
    logic [15:0] raised_target_bias_reg, flare_bias_reg;
    logic [7:0]  raised_hold_speed_limit_reg;
    logic signed [7:0] ac_comp_reg;
    logic [15:0] valve_pulse_period_reg;
    logic        acc_ok;
    logic        wr_en;
    logic        tbl_we [4];
    logic [31:0] rdata_next;
    logic [RPM_W-1:0] target_reg;
    logic signed [7:0] learned_reg;
    logic [DUTY_W-1:0] duty_reg;
    idle_state_t state_reg;
    logic        loop_active_reg;

    assign acc_ok = PSEL_I && PENABLE_I;
    assign wr_en  = acc_ok && PWRITE_I;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            enable_reg <= 1'b0;
            valve_output_select_reg <= 2'h0;
            loop_upper_speed_reg <= 16'h06a4;
            loop_lower_speed_reg <= 16'h0190;
            throttle_enter_level_reg <= 8'h03;
            throttle_exit_level_reg <= 8'h03;
            correction_ceiling_reg <= 8'sh0f;
            correction_floor_reg <= -8'sh05;
            lower_deadzone_reg <= 16'h0019;
            upper_deadzone_reg <= 16'h0032;
            loop_update_interval_reg <= 16'h00c8;
            ac_delay_reg <= 8'h01;
            raised_hold_time_reg <= 8'h02;
            flare_time_reg <= 8'h0a;
            raised_target_bias_reg <= 16'h0000;
            flare_bias_reg <= 16'h0000;
            raised_hold_speed_limit_reg <= 8'hff;
            ac_comp_reg <= 8'sh05;
            valve_pulse_period_reg <= 16'(PERIOD_US_DEF);
        end else if (wr_en) begin
            unique case (PADDR_I)
                A_CTRL: begin
                    enable_reg <= PWDATA_I[CTRL_EN_BIT];
                    valve_output_select_reg <= PWDATA_I[CTRL_SEL_LO+:2];
                end
                A_LOOP_SPD: {loop_upper_speed_reg, loop_lower_speed_reg} <= PWDATA_I;
                A_THR_LVL: {throttle_exit_level_reg, throttle_enter_level_reg} <= PWDATA_I[15:0];
                A_CORR_LIM: {correction_ceiling_reg, correction_floor_reg} <= PWDATA_I[15:0];
                A_DEADZONE: {upper_deadzone_reg, lower_deadzone_reg} <= PWDATA_I;
                A_TIMES: {loop_update_interval_reg, ac_delay_reg, raised_hold_time_reg}
                    <= PWDATA_I;
                A_RAISED: {raised_hold_speed_limit_reg, flare_time_reg, raised_target_bias_reg}
                    <= PWDATA_I;
                A_COMP: {flare_bias_reg, ac_comp_reg} <= PWDATA_I[23:0];
                A_PERIOD: valve_pulse_period_reg <= PWDATA_I[15:0];
                default: ;
            endcase
        end
    end

    for (genvar t = 0; t < 4; t++) begin : g_we
        assign tbl_we[t] = wr_en && (PADDR_I == A_TBL_WR) && (PWDATA_I[13:12] == 2'(t));
    end

    always_comb begin
        rdata_next = 32'h0;
        unique case (PADDR_I)
            A_CTRL:     rdata_next = {29'h0, valve_output_select_reg, enable_reg};
            A_LOOP_SPD: rdata_next = {loop_upper_speed_reg, loop_lower_speed_reg};
            A_THR_LVL:  rdata_next = {16'h0, throttle_exit_level_reg, throttle_enter_level_reg};
            A_CORR_LIM: rdata_next = {16'h0, correction_ceiling_reg, correction_floor_reg};
            A_DEADZONE: rdata_next = {upper_deadzone_reg, lower_deadzone_reg};
            A_TIMES:    rdata_next = {loop_update_interval_reg, ac_delay_reg,
                                      raised_hold_time_reg};
            A_RAISED:   rdata_next = {raised_hold_speed_limit_reg, flare_time_reg,
                                      raised_target_bias_reg};
            A_COMP:     rdata_next = {8'h0, flare_bias_reg, ac_comp_reg};
            A_PERIOD:   rdata_next = {16'h0, valve_pulse_period_reg};
            A_STATUS:   rdata_next = {11'h0, COMPRESSOR_O, loop_active_reg, state_reg,
                                      1'b0, duty_reg, learned_reg};
            A_TARGET:   rdata_next = {16'h0, target_reg};
            default:    rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            PRDATA_O  <= 32'h0;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I && !PENABLE_I;
            PRDATA_O  <= rdata_next;
            PSLVERR_O <= PSEL_I && !PENABLE_I && (PADDR_I > A_PERIOD);
        end
    end

    // ****************************************************************
    // Time bases
    // ****************************************************************
    logic [15:0] ms_cnt_reg;
    logic [15:0] ms_div_reg;
    logic        ms_tick;
    logic        s_tick;
    logic [9:0]  s_div_reg;
    assign ms_tick = (ms_cnt_reg == 16'(MS_CYCLES - 1));
    assign s_tick  = ms_tick && (s_div_reg == 10'(S_TICKS - 1));
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || ms_tick) begin
            ms_cnt_reg <= 16'h0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 16'h1;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || s_tick) begin
            s_div_reg <= 10'h0;
        end else if (ms_tick) begin
            s_div_reg <= s_div_reg + 10'h1;
        end
    end

    // ****************************************************************
    // Tables
    // ****************************************************************
    logic [7:0] open_loop_duty_table_q, base_q, throttle_follower_table_q, spark_assist_table_q;
    logic [RPM_W-1:0] err_abs;
    logic              err_below;
    idle_table_mem #(.AW(TBL_AW), .DW(8)) u_open (
        .clk_i(CLK_I), .we_i(tbl_we[0]), .waddr_i(PWDATA_I[11:8]), .wdata_i(PWDATA_I[7:0]),
        .raddr_i(target_reg[11:8]), .rdata_o(open_loop_duty_table_q));
    idle_table_mem #(.AW(TBL_AW), .DW(8)) u_base (
        .clk_i(CLK_I), .we_i(tbl_we[1]), .waddr_i(PWDATA_I[11:8]), .wdata_i(PWDATA_I[7:0]),
        .raddr_i(sens_reg.coolant[7:4]), .rdata_o(base_q));
    idle_table_mem #(.AW(TBL_AW), .DW(8)) u_follow (
        .clk_i(CLK_I), .we_i(tbl_we[2]), .waddr_i(PWDATA_I[11:8]), .wdata_i(PWDATA_I[7:0]),
        .raddr_i(sens_reg.throttle[3:0]), .rdata_o(throttle_follower_table_q));
    idle_table_mem #(.AW(TBL_AW), .DW(8)) u_spark (
        .clk_i(CLK_I), .we_i(tbl_we[3]), .waddr_i(PWDATA_I[11:8]), .wdata_i(PWDATA_I[7:0]),
        .raddr_i(err_abs[7:4]), .rdata_o(spark_assist_table_q));

    // ****************************************************************
    // Target: base + start flare + raised bias
    // ****************************************************************
    logic [15:0] flare_reg;
    logic [15:0] flare_step;
    logic        started_d_reg;
    logic [7:0]  raised_cnt_reg;
    logic        raised_on;
    assign flare_step = flare_bias_reg / 16'({8'h0, flare_time_reg} | 16'h1);
    always_ff @(posedge CLK_I) begin
        started_d_reg <= SYS_RST_I ? 1'b0 : sens_reg.engine_started;
        if (SYS_RST_I) begin
            flare_reg <= 16'h0;
        end else if (sens_reg.engine_started && !started_d_reg) begin
            flare_reg <= flare_bias_reg;
        end else if (s_tick) begin
            flare_reg <= (flare_reg > flare_step) ? flare_reg - flare_step : 16'h0;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || state_reg == ST_OFF) begin
            raised_cnt_reg <= 8'h0;
        end else if (s_tick && raised_cnt_reg != raised_hold_time_reg) begin
            raised_cnt_reg <= raised_cnt_reg + 8'h1;
        end
    end
    assign raised_on = (state_reg != ST_OFF) && ((raised_cnt_reg < raised_hold_time_reg)
        || (sens_reg.vehicle_speed > raised_hold_speed_limit_reg));
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            target_reg <= 16'h0;
        end else begin
            target_reg <= {base_q, 4'h0} + flare_reg
                + (raised_on ? raised_target_bias_reg : 16'h0);
        end
    end
    assign err_below = sens_reg.engine_rpm < target_reg;
    assign err_abs   = err_below ? target_reg - sens_reg.engine_rpm
                                 : sens_reg.engine_rpm - target_reg;

    // ****************************************************************
    // Loop gating and state
    // ****************************************************************
    logic thr_ok_reg;
    logic speed_ok;
    logic [15:0] upd_cnt_reg;
    logic        upd_tick;
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            thr_ok_reg <= 1'b0;
        end else if (sens_reg.throttle < throttle_enter_level_reg) begin
            thr_ok_reg <= 1'b1;
        end else if (sens_reg.throttle > throttle_exit_level_reg) begin
            thr_ok_reg <= 1'b0;
        end
    end
    assign speed_ok = (sens_reg.engine_rpm < loop_upper_speed_reg)
        && (sens_reg.engine_rpm > loop_lower_speed_reg);
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || upd_tick) begin
            upd_cnt_reg <= 16'h0;
        end else if (ms_tick) begin
            upd_cnt_reg <= upd_cnt_reg + 16'h1;
        end
    end
    assign upd_tick = ms_tick && (upd_cnt_reg + 16'h1 >= loop_update_interval_reg);
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || !enable_reg || !thr_ok_reg) begin
            state_reg <= ST_OFF;
        end else begin
            unique case (state_reg)
                ST_OFF:   state_reg <= ST_ENTER;
                ST_ENTER: state_reg <= ST_LOOP;
                ST_LOOP:  state_reg <= ST_LOOP;
                default:  state_reg <= ST_OFF;
            endcase
        end
    end
    always_ff @(posedge CLK_I) begin
        loop_active_reg <= !SYS_RST_I && (state_reg == ST_LOOP) && speed_ok;
    end

    // ****************************************************************
    // Learned correction
    // ****************************************************************
    logic in_dead;
    assign in_dead = err_below ? (err_abs <= lower_deadzone_reg)
                               : (err_abs <= upper_deadzone_reg);
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || state_reg != ST_LOOP) begin
            learned_reg <= 8'sh0;
        end else if (loop_active_reg && upd_tick && !in_dead) begin
            if (err_below) begin
                learned_reg <= (learned_reg >= correction_ceiling_reg) ? correction_ceiling_reg
                             : learned_reg + 8'sh1;
            end else begin
                learned_reg <= (learned_reg <= correction_floor_reg) ? correction_floor_reg
                             : learned_reg - 8'sh1;
            end
        end
    end

    // ****************************************************************
    // Compressor delay and duty sum
    // ****************************************************************
    logic [7:0] ac_cnt_reg;
    logic signed [10:0] duty_sum;
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || !sens_reg.ac_request) begin
            ac_cnt_reg   <= 8'h0;
            COMPRESSOR_O <= 1'b0;
        end else begin
            if (s_tick && ac_cnt_reg != ac_delay_reg) begin
                ac_cnt_reg <= ac_cnt_reg + 8'h1;
            end
            COMPRESSOR_O <= (ac_cnt_reg == ac_delay_reg);
        end
    end
    assign duty_sum = $signed({3'h0, open_loop_duty_table_q})
        + $signed({7'h0, throttle_follower_table_q[7:4]})
        + 11'(learned_reg)
        + (COMPRESSOR_O ? 11'(ac_comp_reg) : 11'sh0);
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || state_reg == ST_OFF) begin
            duty_reg <= 7'h0;
        end else if (duty_sum < 11'sh0) begin
            duty_reg <= 7'h0;
        end else if (duty_sum > $signed({4'h0, DUTY_FULL})) begin
            duty_reg <= DUTY_FULL;
        end else begin
            duty_reg <= duty_sum[6:0];
        end
    end

    // ****************************************************************
    // PWM and spark trim
    // ****************************************************************
    logic [15:0] us_pos_reg;
    logic [5:0]  us_div_reg;
    logic        pwm_on;
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || us_div_reg == 6'(US_CYCLES - 1)) begin
            us_div_reg <= 6'h0;
        end else begin
            us_div_reg <= us_div_reg + 6'h1;
        end
        if (SYS_RST_I) begin
            us_pos_reg <= 16'h0;
        end else if (us_div_reg == 6'(US_CYCLES - 1)) begin
            us_pos_reg <= (us_pos_reg + 16'h1 >= valve_pulse_period_reg) ? 16'h0
                        : us_pos_reg + 16'h1;
        end
    end
    assign pwm_on = 32'(us_pos_reg) * 32'(PCT_MAX) < 32'(valve_pulse_period_reg) * 32'(duty_reg);
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            BYPASS_AIR_VALVE_O <= '0;
            SPARK_TRIM_O       <= 8'sh0;
        end else begin
            BYPASS_AIR_VALVE_O <= 4'(pwm_on) << valve_output_select_reg;
            SPARK_TRIM_O <= !loop_active_reg ? 8'sh0
                : (err_below ? $signed(spark_assist_table_q)
                             : -$signed(spark_assist_table_q));
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence enter_seq;
        state_reg == ST_OFF ##1 state_reg == ST_ENTER;
    endsequence
    corr_ceiling_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        learned_reg <= correction_ceiling_reg || $changed(correction_ceiling_reg)
        || $past(state_reg) != ST_LOOP) else $error("ceiling exceeded");
    corr_floor_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state_reg == ST_LOOP && $stable(correction_floor_reg) && learned_reg < 8'sh0
        |-> learned_reg >= correction_floor_reg) else $error("floor crossed");
    entry_zero_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        enter_seq |=> learned_reg == 8'sh0) else $error("entry not open loop");
    dead_hold_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        in_dead && state_reg == ST_LOOP |=> $stable(learned_reg))
        else $error("deadzone moved");
    gate_speed_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !speed_ok && !loop_active_reg |=> $stable(learned_reg) || state_reg != ST_LOOP)
        else $error("loop outside speed");
    duty_range_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        duty_reg <= DUTY_FULL) else $error("duty over full");
    thr_exit_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        sens_reg.throttle > throttle_exit_level_reg && sens_reg.throttle
        >= throttle_enter_level_reg |=> !thr_ok_reg ##1 state_reg == ST_OFF)
        else $error("throttle exit missed");
    comp_off_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !sens_reg.ac_request |=> !COMPRESSOR_O) else $error("compressor early");
    valve_onehot_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        $onehot0(BYPASS_AIR_VALVE_O)) else $error("two valve outputs");
endmodule : idle_air_pwm_control

// *** src/idle_table_mem.sv ***
`timescale 1ns/1ps
module idle_table_mem #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_reg [2**AW];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end
endmodule : idle_table_mem
